// File: rtl/mcs_pkg.sv
/*
 * Constants and carrier types for the main clock source control block.
 * Assumes a single system clock; oscillator clocks arrive as sampled levels.
 */
package mcs_pkg;
    // ==========================================================
    // fast rc frequency codes
    localparam logic [1:0] MCS_RC_4MHZ     = 2'h0;
    localparam logic [1:0] MCS_RC_8MHZ     = 2'h1;
    localparam logic [1:0] MCS_RC_12MHZ    = 2'h2;
    localparam logic [1:0] MCS_RC_DEFAULT  = MCS_RC_4MHZ;
    // ==========================================================
    // timing
    localparam int unsigned MCS_SLOW_DIV   = 8;
    localparam logic [2:0]  MCS_DIV_LAST   = 3'h7;
    localparam logic [7:0]  MCS_CNT_ZERO   = 8'h00;
    localparam int unsigned MCS_SYNC_WAIT  = 2;
    localparam logic [1:0]  MCS_SYNC_LAST  = 2'h1;

    // ==========================================================
    // switch states, gray along the path
    typedef enum logic [1:0] {
        MCS_ST_IDLE = 2'b00,
        MCS_ST_GATE = 2'b01,
        MCS_ST_WAIT = 2'b11,
        MCS_ST_OPEN = 2'b10
    } mcs_state_t;

    typedef struct packed {
        logic       fast_rc_enable;
        logic [1:0] fast_rc_freq_select;
        logic       xtal_enable;
        logic       xtal_bypass;
        logic       main_source_select;
        logic [7:0] xtal_startup_count;
        logic       irq_mask_stable;
        logic       irq_mask_switch;
    } mcs_cfg_t;

    typedef struct packed {
        logic xtal_stable_flag;
        logic source_switch_done;
        logic main_is_xtal;
    } mcs_stat_t;
endpackage

// File: rtl/mcs_startup.sv
/*
 * Crystal start-up counter: counts down on slow clock divided by eight.
 * Assumes slow_tick is a one-cycle enable at the slow clock rate.
 */
`timescale 1ns/10ps
`default_nettype none
module mcs_startup
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // control
    input  wire logic       slow_tick,
    input  wire logic       xtal_enable,
    input  wire logic [7:0] xtal_startup_count,
    // status
    output logic            xtal_stable_flag
);
    typedef struct packed {
        logic       en_d;
        logic [2:0] div;
        logic [7:0] cnt;
        logic       stable;
    } mcs_su_t;

    mcs_su_t st_reg;
    mcs_su_t st_next;

    // ==========================================================
    // next state
    always_comb
    begin
        st_next = st_reg;
        st_next.en_d = xtal_enable;
        if (xtal_enable && !st_reg.en_d)
        begin
            st_next.cnt    = xtal_startup_count;
            st_next.div    = '0;
            st_next.stable = 1'b0;
        end
        else if (!xtal_enable)
        begin
            st_next.stable = 1'b0;
        end
        else if (slow_tick && !st_reg.stable)
        begin
            st_next.div = st_reg.div + 3'h1;
            if (st_reg.cnt == mcs_pkg::MCS_CNT_ZERO)
            begin
                st_next.stable = 1'b1;
            end
            else if (st_reg.div == mcs_pkg::MCS_DIV_LAST)
            begin
                st_next.cnt = st_reg.cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign xtal_stable_flag = st_reg.stable;

    AST_LOAD_CLEARS: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(xtal_enable) |=> !xtal_stable_flag && st_reg.cnt == $past(xtal_startup_count))
        else $error("start-up counter not loaded on enable");
    AST_DECREMENT: assert property (@(posedge sys_clk) disable iff (!arst_n)
        xtal_enable && st_reg.en_d && slow_tick && !st_reg.stable
        && st_reg.div == mcs_pkg::MCS_DIV_LAST && st_reg.cnt != mcs_pkg::MCS_CNT_ZERO
        |=> st_reg.cnt == $past(st_reg.cnt) - 8'h01)
        else $error("counter did not step once per eight slow ticks");
    AST_STABLE_AT_ZERO: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(xtal_stable_flag) |-> $past(st_reg.cnt) == mcs_pkg::MCS_CNT_ZERO)
        else $error("stable flag rose before counter reached zero");
endmodule // mcs_startup
`default_nettype wire

// File: rtl/mcs_main_clock_ctrl.sv
/*
 * Main clock source control: fast rc / crystal selection with a
 * break-before-make switch, crystal start-up timing and status interrupt.
 * Assumes oscillator clocks are sampled levels synchronous to sys_clk and
 * that slow_clock_tick marks each slow clock edge; slow clock is never gated.
 */
// Summary of operation
// - fast rc: three frequencies, lowest after reset
// - start-up counter decrements per slow clock/8
// - counter at zero sets crystal stable
// - stable flag and mask raise interrupt
// - select bit: rc clear, crystal set
// - rc forced at start and in wait
// - source change is glitch-free
// - switch-done status after switch sequence
// - switch-done and mask raise interrupt
// - frequency meter sees selected main clock
// - slow clock runs permanently, never gated
`timescale 1ns/10ps
`default_nettype none
module mcs_main_clock_ctrl
(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    // configuration
    input  wire mcs_pkg::mcs_cfg_t cfg,
    input  wire logic             wait_mode,
    // oscillator clocks as levels
    input  wire logic             slow_clock_tick,
    input  wire logic             fast_rc_clk,
    input  wire logic             xtal_input_pin,
    input  wire logic             xtal_osc_clk,
    // outputs
    output logic                  main_clock,
    output logic                  freq_meter_clk,
    output logic                  slow_clock_run,
    output logic [1:0]            fast_rc_freq,
    output mcs_pkg::mcs_stat_t    status,
    output logic                  irq
);
    typedef struct packed {
        mcs_pkg::mcs_state_t fsm;
        logic                sel_xtal;
        logic                target;
        logic [1:0]          wait_cnt;
        logic                done;
        logic [1:0]          rc_freq;
        logic                rc_en_d;
        logic                main_clk;
        logic                irq;
    } mcs_st_t;

    mcs_st_t st_reg;
    mcs_st_t st_next;
    logic    stable;
    logic    want_xtal;
    logic    xtal_src;

    // ==========================================================
    // start-up counter
    mcs_startup u_startup
    (
        .sys_clk            (sys_clk),
        .arst_n             (arst_n),
        .slow_tick          (slow_clock_tick),
        .xtal_enable        (cfg.xtal_enable),
        .xtal_startup_count (cfg.xtal_startup_count),
        .xtal_stable_flag   (stable)
    );

    assign want_xtal = cfg.main_source_select && !wait_mode;
    assign xtal_src  = cfg.xtal_bypass ? xtal_input_pin : xtal_osc_clk;

    // ==========================================================
    // next state
    always_comb
    begin
        st_next = st_reg;
        st_next.rc_en_d = cfg.fast_rc_enable;
        // frequency changes on a write that leaves enable steady high
        if (cfg.fast_rc_enable && st_reg.rc_en_d)
        begin
            st_next.rc_freq = cfg.fast_rc_freq_select;
        end
        case (st_reg.fsm)
            mcs_pkg::MCS_ST_IDLE:
            begin
                if (want_xtal != st_reg.sel_xtal)
                begin
                    st_next.target = want_xtal;
                    st_next.done   = 1'b0;
                    st_next.fsm    = mcs_pkg::MCS_ST_GATE;
                end
            end
            mcs_pkg::MCS_ST_GATE:
            begin
                // gate only while output is low: no runt pulse
                if (!st_reg.main_clk)
                begin
                    st_next.wait_cnt = '0;
                    st_next.fsm      = mcs_pkg::MCS_ST_WAIT;
                end
            end
            mcs_pkg::MCS_ST_WAIT:
            begin
                st_next.wait_cnt = st_reg.wait_cnt + 2'h1;
                if (st_reg.wait_cnt == mcs_pkg::MCS_SYNC_LAST)
                begin
                    st_next.sel_xtal = st_reg.target;
                    st_next.fsm      = mcs_pkg::MCS_ST_OPEN;
                end
            end
            mcs_pkg::MCS_ST_OPEN:
            begin
                st_next.done = 1'b1;
                st_next.fsm  = mcs_pkg::MCS_ST_IDLE;
            end
            default:
            begin
                st_next.fsm = mcs_pkg::MCS_ST_IDLE;
            end
        endcase
        // main clock low while gated between sources
        if (st_next.fsm == mcs_pkg::MCS_ST_WAIT || st_reg.fsm == mcs_pkg::MCS_ST_WAIT)
            st_next.main_clk = 1'b0;
        else
            st_next.main_clk = st_next.sel_xtal ? xtal_src : fast_rc_clk;
        st_next.irq = (stable && cfg.irq_mask_stable)
            || (st_next.done && cfg.irq_mask_switch);
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg         <= '0;
            st_reg.rc_freq <= mcs_pkg::MCS_RC_DEFAULT;
            st_reg.done    <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // ==========================================================
    // outputs
    assign main_clock            = st_reg.main_clk;
    assign freq_meter_clk        = st_reg.main_clk;
    assign slow_clock_run        = 1'b1;
    assign fast_rc_freq          = st_reg.rc_freq;
    assign status.xtal_stable_flag   = stable;
    assign status.source_switch_done = st_reg.done;
    assign status.main_is_xtal       = st_reg.sel_xtal;
    assign irq                   = st_reg.irq;

    AST_WAIT_FORCES_RC: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wait_mode[*8] |-> !st_reg.sel_xtal)
        else $error("rc not selected during wait mode");
    AST_SWITCH_DONE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.fsm == mcs_pkg::MCS_ST_GATE ##1 !$past(st_reg.main_clk)
        |-> ##[1:4] st_reg.done)
        else $error("switch done not reported");
    AST_GAP_LOW: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.fsm == mcs_pkg::MCS_ST_WAIT |-> !main_clock)
        else $error("main clock not held low across switch");
    AST_IRQ_STABLE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        stable && cfg.irq_mask_stable |=> irq)
        else $error("stable interrupt missing");
    AST_IRQ_SWITCH: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(st_reg.done) && cfg.irq_mask_switch |-> irq)
        else $error("switch interrupt missing");
    AST_SELECT: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.fsm == mcs_pkg::MCS_ST_IDLE && st_reg.done |-> st_reg.sel_xtal == st_reg.target)
        else $error("selected source differs from target");
    AST_RC_FREQ: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(cfg.fast_rc_enable) |=> fast_rc_freq == $past(fast_rc_freq))
        else $error("rc frequency changed on the enabling write");
    AST_METER: assert property (@(posedge sys_clk) disable iff (!arst_n)
        freq_meter_clk == main_clock)
        else $error("meter not on main clock");

    COV_TO_XTAL: cover property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(status.main_is_xtal));
    COV_STABLE: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(stable));
    COV_WAIT_BACK: cover property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.sel_xtal && wait_mode ##[1:8] !st_reg.sel_xtal);
    // a source level stuck high keeps the gate from closing: switch never ends
    COV_SWITCH_DONE: cover property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(st_reg.done));
    COV_RC_ENABLE: cover property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(cfg.fast_rc_enable));
endmodule // mcs_main_clock_ctrl
`default_nettype wire

// File: tb/tb_top.sv
/*
 * Self-checking bench for the main clock source control block.
 * Assumes the block samples cfg on every sys_clk edge and that oscillator
 * inputs are plain levels; slow ticks come from a free divider below.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // ==========================================================
    // stimulus and observation
    logic               sys_clk         = 1'b0;
    logic               arst_n          = 1'b0;
    mcs_pkg::mcs_cfg_t  cfg             = '0;
    logic               wait_mode       = 1'b0;
    logic               slow_clock_tick = 1'b0;
    logic               fast_rc_clk     = 1'b0;
    logic               xtal_input_pin  = 1'b0;
    logic               xtal_osc_clk    = 1'b1;
    logic               main_clock;
    logic               freq_meter_clk;
    logic               slow_clock_run;
    logic [1:0]         fast_rc_freq;
    mcs_pkg::mcs_stat_t status;
    logic               irq;
    int                 mismatches      = 0;
    int                 cmp_count       = 0;
    logic [1:0]         tick_div        = 2'h0;

    mcs_main_clock_ctrl mcs_main_clock_ctrl_inst (
        .sys_clk         (sys_clk),
        .arst_n          (arst_n),
        .cfg             (cfg),
        .wait_mode       (wait_mode),
        .slow_clock_tick (slow_clock_tick),
        .fast_rc_clk     (fast_rc_clk),
        .xtal_input_pin  (xtal_input_pin),
        .xtal_osc_clk    (xtal_osc_clk),
        .main_clock      (main_clock),
        .freq_meter_clk  (freq_meter_clk),
        .slow_clock_run  (slow_clock_run),
        .fast_rc_freq    (fast_rc_freq),
        .status          (status),
        .irq             (irq)
    );

    always #12.5 sys_clk = ~sys_clk;

    // one slow tick every four system cycles, never stopped
    always @(posedge sys_clk)
    begin
        tick_div        <= tick_div + 2'h1;
        slow_clock_tick <= (tick_div == 2'h3);
    end

    // ==========================================================
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // compare at the falling edge; seen and exp are copied when the task is called
    task automatic look(input logic [7:0] seen, input logic [7:0] exp);
        @(negedge sys_clk);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_done(input logic lvl);
        int k;
        k = 0;
        while (status.source_switch_done !== lvl && k < 40)
        begin
            @(negedge sys_clk);
            k++;
        end
        look({7'h0, status.source_switch_done}, {7'h0, lvl});
    endtask

    task automatic final_report();
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================================
    // tests
    initial
    begin
        cfg.fast_rc_enable     = 1'b1;
        cfg.xtal_startup_count = 8'h02;
        cyc(3);
        arst_n <= 1'b1;
        look({6'h0, fast_rc_freq}, {6'h0, mcs_pkg::MCS_RC_DEFAULT});
        look({7'h0, slow_clock_run}, 8'h01);
        look({5'h0, status}, 8'h02);
        look({7'h0, irq}, 8'h00);
        // frequency steps with the oscillator already running
        cyc(1);
        cfg.fast_rc_freq_select <= mcs_pkg::MCS_RC_8MHZ;
        cyc(3);
        look({6'h0, fast_rc_freq}, {6'h0, mcs_pkg::MCS_RC_8MHZ});
        cyc(1);
        cfg.fast_rc_freq_select <= mcs_pkg::MCS_RC_12MHZ;
        cyc(3);
        look({6'h0, fast_rc_freq}, {6'h0, mcs_pkg::MCS_RC_12MHZ});
        // re-enable the rc: frequency must hold on the enabling write
        cyc(1);
        cfg.fast_rc_enable <= 1'b0;
        cyc(2);
        cfg.fast_rc_enable <= 1'b1;
        cyc(1);
        look({6'h0, fast_rc_freq}, {6'h0, mcs_pkg::MCS_RC_12MHZ});
        // crystal start-up: count 2 needs 17 slow ticks
        cyc(1);
        cfg.xtal_enable     <= 1'b1;
        cfg.irq_mask_stable <= 1'b1;
        cyc(40);
        look({7'h0, status.xtal_stable_flag}, 8'h00);
        cyc(110);
        look({7'h0, status.xtal_stable_flag}, 8'h01);
        look({7'h0, irq}, 8'h01);
        cyc(1);
        cfg.irq_mask_stable <= 1'b0;
        cyc(3);
        look({7'h0, irq}, 8'h00);
        // switch to crystal, rc level low and crystal level high
        cyc(1);
        cfg.main_source_select <= 1'b1;
        cfg.irq_mask_switch    <= 1'b1;
        wait_done(1'b0);
        look({7'h0, main_clock}, 8'h00);
        wait_done(1'b1);
        look({7'h0, status.main_is_xtal}, 8'h01);
        cyc(2);
        look({7'h0, main_clock}, 8'h01);
        look({7'h0, freq_meter_clk}, 8'h01);
        look({7'h0, irq}, 8'h01);
        // wait mode forces the rc source back
        cyc(1);
        // gate closes only on a low level, so park the crystal level low
        xtal_osc_clk <= 1'b0;
        wait_mode    <= 1'b1;
        cyc(30);
        look({7'h0, status.main_is_xtal}, 8'h00);
        look({7'h0, freq_meter_clk}, 8'h00);
        cyc(1);
        wait_mode <= 1'b0;
        cyc(30);
        look({7'h0, status.main_is_xtal}, 8'h01);
        // bypass: clock present, bypass on, then crystal off
        cyc(1);
        xtal_input_pin <= 1'b1;
        xtal_osc_clk   <= 1'b0;
        cyc(1);
        cfg.xtal_bypass <= 1'b1;
        cyc(1);
        cfg.xtal_enable <= 1'b0;
        cyc(4);
        look({7'h0, main_clock}, 8'h01);
        look({7'h0, status.xtal_stable_flag}, 8'h00);
        cyc(1);
        cfg.xtal_enable <= 1'b1;
        cyc(8);
        look({7'h0, status.xtal_stable_flag}, 8'h00);
        final_report();
    end

    // whole sequence is under 400 cycles
    initial
    begin
        #(25 * 5000);
        mismatches++;
        final_report();
    end
endmodule // tb_top
`default_nettype wire
